// ---- hdl/tx_pulse_template_access.sv ----
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module tx_pulse_template_access (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [tx_template_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [tx_template_pkg::CH_BITS-1:0] shaper_channel,
	input wire logic [tx_template_pkg::TPL_ADDR_W-1:0] shaper_addr,
	output logic [tx_template_pkg::AMP_W-1:0] shaper_sample,
	output logic [tx_template_pkg::SCALE_W-1:0] shaper_scale
);
	import tx_template_pkg::*;
	// ****************************************
	// bus slave state
	// ****************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} bus_state_t;
	bus_state_t b_q;
	bus_state_t b_d;
	logic [CH_BITS-1:0] ch_sel;
	logic [4:0] reg_off;
	logic word_ok;
	logic [1:0] reg_sel;
	logic reg_hit;
	logic [CHANNELS-1:0] ch_busy;
	logic [7:0] scaling_rd [CHANNELS];
	logic [7:0] access_rd [CHANNELS];
	logic [7:0] sample_rd [CHANNELS];
	logic [SCALE_W-1:0] scale_all [CHANNELS];
	logic [AMP_W-1:0] smp_all [CHANNELS];
	logic wr_take;
	// word index: channel in upper bits, register in lower five
	assign ch_sel = adr_i[ADDR_W-1:ADDR_W-CH_BITS];
	assign reg_off = adr_i[ADDR_W-CH_BITS-1:2];
	assign word_ok = (adr_i[1:0] == 2'b00);
	always_comb begin
		reg_hit = 1'b1;
		reg_sel = 2'd0;
		case (reg_off)
			REG_SCALING: reg_sel = 2'd0;
			REG_ACCESS: reg_sel = 2'd1;
			REG_SAMPLE: reg_sel = 2'd2;
			default: reg_hit = 1'b0;
		endcase
	end
	// one write per bus cycle, taken on the edge that raises ack
	assign wr_take = cyc_i && stb_i && we_i && !b_q.ack && word_ok && reg_hit && sel_i[0];
	// ****************************************
	// channel copies
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			channel_regs u_ch (
				.clk_sys(clk_sys),
				.rst(rst),
				.wr_en(wr_take && (ch_sel == CH_BITS'(g))),
				.reg_sel(reg_sel),
				.wr_data(dat_i[7:0]),
				.shaper_addr(shaper_addr),
				.scaling_rd(scaling_rd[g]),
				.access_rd(access_rd[g]),
				.sample_rd(sample_rd[g]),
				.amplitude_scale(scale_all[g]),
				.shaper_sample(smp_all[g]),
				.busy(ch_busy[g])
			);
		end
	endgenerate
	// ****************************************
	// wishbone answer
	// ****************************************
	always_comb begin
		b_d = b_q;
		b_d.ack = 1'b0;
		if (cyc_i && stb_i && !b_q.ack) begin
			b_d.ack = 1'b1;
			b_d.rdata = 32'h0000_0000;
			if (!we_i && word_ok && reg_hit) begin
				case (reg_sel)
					2'd0: b_d.rdata = {24'h00_0000, scaling_rd[ch_sel]};
					2'd1: b_d.rdata = {24'h00_0000, access_rd[ch_sel]};
					2'd2: b_d.rdata = {24'h00_0000, sample_rd[ch_sel]};
					default: b_d.rdata = 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			b_q <= '{ack: 1'b0, rdata: 32'h0000_0000};
		end else begin
			b_q <= b_d;
		end
	end
	assign ack_o = b_q.ack;
	assign dat_o = b_q.rdata;
	// shaper view of the chosen channel: template sample and scale
	assign shaper_sample = smp_all[shaper_channel];
	assign shaper_scale = scale_all[shaper_channel];
endmodule : tx_pulse_template_access

// ---- hdl/tx_template_pkg.sv ----
package tx_template_pkg;
	// ****************************************
	// address map
	// ****************************************
	localparam int CHANNELS = 8;
	localparam int CH_BITS = 3;
	localparam int ADDR_W = 10;
	localparam logic [4:0] REG_SCALING = 5'h04;
	localparam logic [4:0] REG_ACCESS = 5'h05;
	localparam logic [4:0] REG_SAMPLE = 5'h06;
	localparam logic [4:0] REG_CH_SPACING_BITS = 5'h05;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam logic [5:0] SCALE_RESET = 6'h21;
	localparam logic [7:0] ACCESS_RESET = 8'h00;
	localparam logic [6:0] SAMPLE_RESET = 7'h00;
	localparam int TRIGGER_BIT = 7;
	localparam int DIR_BIT = 6;
	localparam int IV_HI = 5;
	localparam int IV_LO = 4;
	localparam int SMP_HI = 3;
	localparam int SMP_LO = 0;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam int TPL_ADDR_W = 6;
	localparam int TPL_DEPTH = 64;
	localparam int AMP_W = 7;
	localparam int SCALE_W = 6;
	localparam logic [7:0] WORD_ZERO = 8'h00;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_FINISH
	} access_state_t;
endpackage : tx_template_pkg

// ---- hdl/template_ram.sv ----
`timescale 1ns/1ps
module template_ram (
	input wire logic clk_sys,
	input wire logic we,
	input wire logic [tx_template_pkg::TPL_ADDR_W-1:0] addr,
	input wire logic [tx_template_pkg::AMP_W-1:0] wdata,
	input wire logic [tx_template_pkg::TPL_ADDR_W-1:0] raddr,
	output logic [tx_template_pkg::AMP_W-1:0] rdata,
	output logic [tx_template_pkg::AMP_W-1:0] rdata2
);
	import tx_template_pkg::*;
	logic [AMP_W-1:0] mem [TPL_DEPTH];
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
		rdata2 <= mem[raddr];
	end
endmodule : template_ram

// ---- hdl/channel_regs.sv ----
`timescale 1ns/1ps
module channel_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [1:0] reg_sel,
	input wire logic [7:0] wr_data,
	input wire logic [tx_template_pkg::TPL_ADDR_W-1:0] shaper_addr,
	output logic [7:0] scaling_rd,
	output logic [7:0] access_rd,
	output logic [7:0] sample_rd,
	output logic [tx_template_pkg::SCALE_W-1:0] amplitude_scale,
	output logic [tx_template_pkg::AMP_W-1:0] shaper_sample,
	output logic busy
);
	import tx_template_pkg::*;
	// ****************************************
	// per-channel state
	// ****************************************
	typedef struct packed {
		logic [SCALE_W-1:0] scale;
		logic trigger;
		logic dir;
		logic [1:0] interval_index;
		logic [3:0] sample_index;
		logic [AMP_W-1:0] sample_amplitude;
		access_state_t st;
	} ch_state_t;
	ch_state_t s_q;
	ch_state_t s_d;
	logic ram_we;
	logic [AMP_W-1:0] ram_rdata;
	logic [TPL_ADDR_W-1:0] ram_addr;
	assign ram_addr = {s_q.interval_index, s_q.sample_index};
	assign ram_we = (s_q.st == ST_ACCESS) && (s_q.dir == DIR_WRITE);
	template_ram u_ram (
		.clk_sys(clk_sys),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(s_q.sample_amplitude),
		.raddr(shaper_addr),
		.rdata(ram_rdata),
		.rdata2(shaper_sample)
	);
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			ST_IDLE: begin
				if (wr_en && reg_sel == 2'd0) begin
					s_d.scale = wr_data[SCALE_W-1:0];
				end
				if (wr_en && reg_sel == 2'd1) begin
					s_d.trigger = wr_data[TRIGGER_BIT];
					s_d.dir = wr_data[DIR_BIT];
					s_d.interval_index = wr_data[IV_HI:IV_LO];
					s_d.sample_index = wr_data[SMP_HI:SMP_LO];
					if (wr_data[TRIGGER_BIT]) begin
						s_d.st = ST_ACCESS;
					end
				end
				if (wr_en && reg_sel == 2'd2) begin
					s_d.sample_amplitude = wr_data[AMP_W-1:0];
				end
			end
			ST_ACCESS: begin
				s_d.st = ST_FINISH;
			end
			ST_FINISH: begin
				if (s_q.dir == DIR_READ) begin
					s_d.sample_amplitude = ram_rdata;
				end
				s_d.trigger = 1'b0;
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '{scale: SCALE_RESET, trigger: ACCESS_RESET[TRIGGER_BIT],
				dir: ACCESS_RESET[DIR_BIT], interval_index: ACCESS_RESET[IV_HI:IV_LO],
				sample_index: ACCESS_RESET[SMP_HI:SMP_LO],
				sample_amplitude: SAMPLE_RESET, st: ST_IDLE};
		end else begin
			s_q <= s_d;
		end
	end
	assign scaling_rd = {2'b00, s_q.scale};
	assign access_rd = {s_q.trigger, s_q.dir, s_q.interval_index, s_q.sample_index};
	assign sample_rd = {1'b0, s_q.sample_amplitude};
	assign amplitude_scale = s_q.scale;
	assign busy = (s_q.st != ST_IDLE);
endmodule : channel_regs

// ---- tb/tx_template_sva.sv ----
`timescale 1ns/1ps
module tx_template_sva (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [tx_template_pkg::ADDR_W-1:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [tx_template_pkg::CH_BITS-1:0] shaper_channel,
	input wire logic [tx_template_pkg::SCALE_W-1:0] shaper_scale
);
	import tx_template_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ****************************************
	// bus answer
	// ****************************************
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	ack_follows_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked");
	ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	ack_reset_a: assert property (disable iff (1'b0) rst |=> !ack_o)
		else $error("ack during reset");
	// ****************************************
	// register contents
	// ****************************************
	scale_reset_a: assert property (disable iff (1'b0) rst ##1 !rst |-> shaper_scale == SCALE_RESET)
		else $error("scale reset value wrong");
	scale_cause_a: assert property ($changed(shaper_scale) && $stable(shaper_channel) |-> $past(cyc_i && stb_i && we_i))
		else $error("scale changed without write");
	upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	scale_rsvd_a: assert property (ack_o && $past(!we_i && adr_i[6:0] == 7'h10) |-> dat_o[7:6] == 2'b00)
		else $error("scale reserved bits set");
	sample_rsvd_a: assert property (ack_o && $past(!we_i && adr_i[6:0] == 7'h18) |-> !dat_o[7])
		else $error("sample reserved bit set");
	unmapped_zero_a: assert property (ack_o && $past(!we_i && adr_i[6:0] == 7'h00) |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule : tx_template_sva
bind tx_pulse_template_access tx_template_sva tx_template_sva_inst (.clk_sys(clk_sys), .rst(rst),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
	.shaper_channel(shaper_channel), .shaper_scale(shaper_scale));

// ---- tb/tb_tx_pulse_template_access.sv ----
`timescale 1ns/1ps
module tb_tx_pulse_template_access;
	import tx_template_pkg::*;
	typedef struct packed {logic [9:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic clk_sys, rst, cyc_i, stb_i, we_i, ack_o;
	logic [9:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i, wsel;
	logic [2:0] shaper_channel;
	logic [5:0] shaper_addr, shaper_scale;
	logic [6:0] shaper_sample;
	logic [7:0] q;
	int n_fail = 0;
	int checks_done = 0;
	logic [5:0] ad [2] = '{6'h00, 6'h3F};
	logic [7:0] vs [2] = '{8'h2A, 8'h55};
	row_t rows [9] = '{'{10'h010, 8'h36, 8'h36}, '{10'h010, 8'h11, 8'h11}, '{10'h010, 8'h08, 8'h08},
		'{10'h010, 8'h04, 8'h04}, '{10'h010, 8'h21, 8'h21}, '{10'h010, 8'hFF, 8'h3F},
		'{10'h390, 8'h2A, 8'h2A}, '{10'h018, 8'hFF, 8'h7F}, '{10'h000, 8'h5A, 8'h00}};
	tx_pulse_template_access tx_pulse_template_access_inst (.clk_sys(clk_sys), .rst(rst),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .shaper_channel(shaper_channel), .shaper_addr(shaper_addr),
		.shaper_sample(shaper_sample), .shaper_scale(shaper_scale));
	// ****************************************
	// tasks
	// ****************************************
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic [9:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk_sys);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= wsel;
		dat_i <= {24'h00_0000, d};
		// this wait ends when ack_o goes high; the watchdog ends it only if no ack comes
		do begin
			@(posedge clk_sys);
		end while (ack_o !== 1'b1);
		r = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb
	task idle_wait;
		do begin
			wb(10'h014, 1'b0, 8'h00, q);
		end while (q[7] !== 1'b0);
	endtask : idle_wait
	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#1000000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = '0;
		dat_i = '0;
		sel_i = '0;
		wsel = 4'h1;
		shaper_channel = '0;
		shaper_addr = '0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		wb(10'h010, 1'b0, 8'h00, q);
		chk("scale", 8'h21, q);
		wb(10'h014, 1'b0, 8'h00, q);
		chk("control", 8'h00, q);
		wb(10'h018, 1'b0, 8'h00, q);
		chk("sample", {1'b0, SAMPLE_RESET}, q);
		$display("reset test done");
		foreach (rows[i]) begin
			wb(rows[i].a, 1'b1, rows[i].d, q);
			wb(rows[i].a, 1'b0, 8'h00, q);
			chk("register", rows[i].e, q);
		end
		shaper_channel <= 3'd7;
		@(negedge clk_sys);
		chk("scale out", 8'h2A, {2'b00, shaper_scale});
		$display("register table done");
		for (int i = 0; i < 2; i++) begin
			wb(10'h018, 1'b1, vs[i], q);
			wb(10'h014, 1'b1, {2'b10, ad[i]}, q);
			idle_wait();
		end
		shaper_channel <= 3'd0;
		for (int i = 0; i < 2; i++) begin
			wb(10'h018, 1'b1, 8'h00, q);
			wb(10'h014, 1'b1, {2'b11, ad[i]}, q);
			idle_wait();
			wb(10'h018, 1'b0, 8'h00, q); chk("read back", vs[i], q);
			shaper_addr <= ad[i];
			@(negedge clk_sys);
			@(negedge clk_sys);
			chk("shaper", vs[i], {1'b0, shaper_sample});
		end
		$display("template test done");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		wb(10'h010, 1'b0, 8'h00, q);
		chk("scale", 8'h21, q);
		wb(10'h018, 1'b0, 8'h00, q);
		chk("sample", {1'b0, SAMPLE_RESET}, q);
		$display("second reset done");
		// write with byte lane 0 off must leave the scale alone
		wsel = 4'h0;
		wb(10'h010, 1'b1, 8'h08, q);
		wsel = 4'h1;
		wb(10'h010, 1'b0, 8'h00, q);
		chk("lane off", 8'h21, q);
		$display("byte select test done");
		tally_and_finish();
	end
endmodule : tb_tx_pulse_template_access
